// file: hold_arbiter.sv
// holds the bus hold arbiter: hand-off to DMA or master, DMA address
// latch, AT pin turnaround and AT cycle wait-state control
// assumes REF_CLK at 25 MHz, synchronous active-low RST_B, and that the
// pads resolve each two-way pin from its _O and _OE signals
//
// How it works
// R01: peripheral hold request starts arbitration
// R02: pending request raises CPU hold request
// R03: CPU floats buses before granting hold
// R04: CPU grant means CPU released bus
// R05: peripheral grant answers the hold request
// R06: byte strobe latches data onto A15..A8
// R07: word strobe latches data onto A16..A9
// R08: byte enable low marks 8-bit DMA
// R09: word enable low marks 16-bit DMA
// R10: address bit 0 released in master/8-bit DMA
// R11: channel ready low inserts wait states
// R12: slow target pulls ready low promptly
// R13: zero wait ends cycle without more waits
// R14: wide I/O slave input marks 16-bit target
// R15: wide memory slave driven on local hits in master cycles
// R16: I/O read strobe turns around in hold
// R17: drive address bit 20 mask to CPU
// R18: snoop status lines driven during hold
// R19: other AT strobes turn around in hold
// R20: grant waits for CPU; drop on release
// R21: hold, grant, address idle after reset
`timescale 1ns/1ps
`include "hold_arb_consts.svh"
module hold_arbiter (
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic       DMA_HOLD_REQUEST,       // from peripheral controller
  input  wire logic       CPU_BUS_GRANT,          // from CPU
  output logic            CPU_HOLD_REQUEST,       // to CPU
  output logic            PERIPHERAL_BUS_GRANT,   // to peripheral controller
  input  wire logic       BYTE_DMA_ADDR_STROBE,
  input  wire logic       WORD_DMA_ADDR_STROBE,
  input  wire logic       BYTE_DMA_ADDR_ENABLE_N,
  input  wire logic       WORD_DMA_ADDR_ENABLE_N,
  input  wire logic [7:0] LOCAL_PERIPH_DATA_LOW,
  output logic [8:0]      DMA_ADDR_O,             // A16..A8
  output logic            DMA_ADDR_OE,
  output logic            DMA8_CYCLE,
  output logic            DMA16_CYCLE,
  output logic            MASTER_CYCLE,
  input  wire logic       CPU_ADDR_BIT0,          // own address bit 0
  input  wire logic       SYS_ADDR_BIT0_I,
  output logic            SYS_ADDR_BIT0_O,
  output logic            SYS_ADDR_BIT0_OE,
  output logic            SAMPLED_ADDR_BIT0,
  input  wire logic       CHANNEL_READY,
  input  wire logic       ZERO_WAIT_N,
  input  wire logic       AT_CYCLE_START,         // pulse from AT sequencer
  output logic            AT_CYCLE_DONE,
  output logic            AT_CYCLE_BUSY,
  input  wire logic       IO_WIDE_SLAVE_N,
  output logic            IO_WIDE_ACTIVE,
  input  wire logic       LOCAL_MEM_HIT,          // master hits local memory
  input  wire logic       MEM_WIDE_SLAVE_N_I,
  output logic            MEM_WIDE_SLAVE_N_O,
  output logic            MEM_WIDE_SLAVE_N_OE,
  output logic            MEM_WIDE_ACTIVE,
  input  wire logic [3:0] CPU_AT_STROBES_N,       // at_io_read_n, at_io_write_n, mrd, mwr
  input  wire logic [3:0] AT_STROBES_N_I,
  output logic [3:0]      AT_STROBES_N_O,
  output logic            AT_STROBES_N_OE,
  output logic [3:0]      DMA_STROBES_N,          // sampled in hold
  input  wire logic       A20_GATE,               // 1 lets A20 pass
  output logic            ADDR20_MASK_N,
  output logic            CPU_ADDR_STATUS_N_O,
  output logic            CPU_MEM_OR_IO_N_O,
  output logic            CPU_WRITE_READ_N_O,
  output logic            SNOOP_OE
);
  sync_bus_if sb ();                  // synchronised pin levels
  hold_arb_pkg::arb_state_t state;    // arbitration state
  hold_arb_pkg::arb_state_t next_state;
  logic       hold_req;               // synchronised hold request
  logic       cpu_grant;              // synchronised CPU grant
  logic       in_grant;               // bus handed to peripheral
  logic       dma8;                   // 8-bit DMA decode
  logic       dma16;                  // 16-bit DMA decode
  logic       master;                 // master cycle decode
  logic       mem_cmd;                // any memory strobe low in hold
  logic       mem_cmd_prev;           // last cycle's memory strobe
  logic [2:0] wait_count;             // default waits still to run

  // pins in sb.raw pass the three-stage synchroniser; LOCAL_MEM_HIT, A20_GATE, CPU_ADDR_BIT0 and CPU_AT_STROBES_N do not
  // strobes keep their port order: io read lands on the lowest strobe bit
  assign sb.raw = {AT_STROBES_N_I, MEM_WIDE_SLAVE_N_I, SYS_ADDR_BIT0_I,
                   IO_WIDE_SLAVE_N, ZERO_WAIT_N, CHANNEL_READY,
                   LOCAL_PERIPH_DATA_LOW, WORD_DMA_ADDR_ENABLE_N,
                   BYTE_DMA_ADDR_ENABLE_N, WORD_DMA_ADDR_STROBE,
                   BYTE_DMA_ADDR_STROBE, CPU_BUS_GRANT, DMA_HOLD_REQUEST};

  pin_sync u_sync (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .bus   (sb)
  );

  assign hold_req  = sb.stable[`B_HOLD_REQ];   // R01
  assign cpu_grant = sb.stable[`B_CPU_GRANT];
  assign in_grant  = (state == hold_arb_pkg::ARB_GRANT);
  assign dma8      = in_grant && !sb.stable[`B_BYTE_EN_N];    // R08
  assign dma16     = in_grant && !sb.stable[`B_WORD_EN_N];    // R09
  assign master    = in_grant && sb.stable[`B_BYTE_EN_N] && sb.stable[`B_WORD_EN_N];
  assign mem_cmd   = in_grant && (!sb.stable[`B_MRD_N] || !sb.stable[`B_MWR_N]);

  // next arbitration state; the CPU floats its pins before granting,
  // so the grant is the only safe point to hand the bus over
  always_comb
  begin
    next_state = state;
    case (state)
      hold_arb_pkg::ARB_IDLE:
        if (hold_req)
          next_state = hold_arb_pkg::ARB_REQ;      // R02
      hold_arb_pkg::ARB_REQ:
        if (!hold_req)
          next_state = hold_arb_pkg::ARB_IDLE;     // R20
        else if (cpu_grant)
          next_state = hold_arb_pkg::ARB_GRANT;    // R04 R03
      hold_arb_pkg::ARB_GRANT:
        if (!hold_req)
          next_state = hold_arb_pkg::ARB_IDLE;     // R20
        else if (!cpu_grant)
          next_state = hold_arb_pkg::ARB_REQ;      // CPU took the bus back
      default:
        next_state = hold_arb_pkg::ARB_IDLE;
    endcase
  end

  // arbitration state and the two handshake outputs
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      state                <= hold_arb_pkg::ARB_IDLE;   // R21
      CPU_HOLD_REQUEST     <= 1'b0;
      PERIPHERAL_BUS_GRANT <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      CPU_HOLD_REQUEST     <= (next_state != hold_arb_pkg::ARB_IDLE);  // R02
      PERIPHERAL_BUS_GRANT <= (next_state == hold_arb_pkg::ARB_GRANT); // R05 R20
    end
  end

  // cycle type decode, shown for the AT sequencer
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      DMA8_CYCLE   <= 1'b0;
      DMA16_CYCLE  <= 1'b0;
      MASTER_CYCLE <= 1'b0;
    end
    else
    begin
      DMA8_CYCLE   <= dma8;    // R08
      DMA16_CYCLE  <= dma16;   // R09
      MASTER_CYCLE <= master;
    end
  end

  // DMA upper address latch: transparent while a strobe stands high;
  // byte mode leaves A16 low, word mode leaves A8 low
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      DMA_ADDR_O  <= `DMA_ADDR_RST;   // R21
      DMA_ADDR_OE <= 1'b0;
    end
    else
    begin
      if (sb.stable[`B_BYTE_STB])
        DMA_ADDR_O <= {1'b0, sb.stable[`B_DATA_HI:`B_DATA_LO]};  // R06
      else if (sb.stable[`B_WORD_STB])
        DMA_ADDR_O <= {sb.stable[`B_DATA_HI:`B_DATA_LO], 1'b0};  // R07
      DMA_ADDR_OE <= dma8 || dma16;
    end
  end

  // address bit 0: the master or 8-bit DMA controller owns it then
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      SYS_ADDR_BIT0_O   <= 1'b0;
      SYS_ADDR_BIT0_OE  <= 1'b1;
      SAMPLED_ADDR_BIT0 <= 1'b0;
    end
    else
    begin
      SYS_ADDR_BIT0_O   <= CPU_ADDR_BIT0;
      SYS_ADDR_BIT0_OE  <= !(master || dma8);   // R10
      SAMPLED_ADDR_BIT0 <= sb.stable[`B_ADDR0];
    end
  end

  // AT cycle length: zero wait ends at once, channel ready low stretches
  // without limit, so a stuck target hangs the cycle by design
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      AT_CYCLE_BUSY <= 1'b0;
      AT_CYCLE_DONE <= 1'b0;
      wait_count    <= 3'h0;
    end
    else
    begin
      AT_CYCLE_DONE <= 1'b0;
      if (AT_CYCLE_START && !AT_CYCLE_BUSY)
      begin
        AT_CYCLE_BUSY <= 1'b1;
        wait_count    <= `AT_DEFAULT_WAITS;
      end
      else if (AT_CYCLE_BUSY)
      begin
        if (!sb.stable[`B_ZERO_WAIT_N])
        begin
          AT_CYCLE_BUSY <= 1'b0;     // R13
          AT_CYCLE_DONE <= 1'b1;
        end
        else if (!sb.stable[`B_CH_READY])
          wait_count <= wait_count;  // R11
        else if (wait_count == 3'h0)
        begin
          AT_CYCLE_BUSY <= 1'b0;
          AT_CYCLE_DONE <= 1'b1;
        end
        else
          wait_count <= wait_count - 3'h1;
      end
    end
  end

  // slave width indications and the wide memory slave drive
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      IO_WIDE_ACTIVE      <= 1'b0;
      MEM_WIDE_ACTIVE     <= 1'b0;
      MEM_WIDE_SLAVE_N_O  <= 1'b1;
      MEM_WIDE_SLAVE_N_OE <= 1'b0;
    end
    else
    begin
      IO_WIDE_ACTIVE      <= !sb.stable[`B_IO_WIDE_N];   // R14
      MEM_WIDE_ACTIVE     <= !sb.stable[`B_MEM_WIDE_N];
      MEM_WIDE_SLAVE_N_O  <= 1'b0;                        // local memory is 16-bit
      MEM_WIDE_SLAVE_N_OE <= master && LOCAL_MEM_HIT;     // R15
    end
  end

  // AT command strobes turn around while the peripheral owns the bus
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      AT_STROBES_N_O  <= 4'hF;
      AT_STROBES_N_OE <= 1'b1;
      DMA_STROBES_N   <= 4'hF;
    end
    else
    begin
      AT_STROBES_N_O  <= CPU_AT_STROBES_N;
      AT_STROBES_N_OE <= (next_state != hold_arb_pkg::ARB_GRANT);  // R16 R19
      DMA_STROBES_N   <= {sb.stable[`B_MWR_N], sb.stable[`B_MRD_N],
                          sb.stable[`B_AT_IO_WRITE_N_N], sb.stable[`B_AT_IO_READ_N_N]};
    end
  end

  // snoop status: one address-status pulse when a memory strobe falls with none low before,
  // so a write straight after a read gets no pulse of its own
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      mem_cmd_prev        <= 1'b0;
      SNOOP_OE            <= 1'b0;
      CPU_ADDR_STATUS_N_O <= 1'b1;
      CPU_MEM_OR_IO_N_O   <= 1'b1;
      CPU_WRITE_READ_N_O  <= 1'b0;
    end
    else
    begin
      mem_cmd_prev        <= mem_cmd;
      SNOOP_OE            <= in_grant;                      // R18
      CPU_ADDR_STATUS_N_O <= !(mem_cmd && !mem_cmd_prev);   // R18
      CPU_MEM_OR_IO_N_O   <= mem_cmd;
      CPU_WRITE_READ_N_O  <= in_grant && !sb.stable[`B_MWR_N];
    end
  end

  // address bit 20 mask follows the gate control
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      ADDR20_MASK_N <= `A20_MASK_RST;
    else
      ADDR20_MASK_N <= A20_GATE;   // R17
  end

  chk_hold_on_req: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R02
    (state == hold_arb_pkg::ARB_IDLE && hold_req) |=> CPU_HOLD_REQUEST)
    else $error("hold request not raised");
  chk_grant_needs_cpu: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R20
    $rose(PERIPHERAL_BUS_GRANT) |-> $past(cpu_grant) && $past(hold_req))
    else $error("peripheral grant without cpu grant");
  chk_release_on_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R20
    (state != hold_arb_pkg::ARB_IDLE && !hold_req) |=> !CPU_HOLD_REQUEST && !PERIPHERAL_BUS_GRANT)
    else $error("hold not released");
  chk_grant_answer: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R05
    (state == hold_arb_pkg::ARB_REQ && hold_req && cpu_grant) |=> PERIPHERAL_BUS_GRANT)
    else $error("grant not passed on");
  chk_byte_addr: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R06
    sb.stable[`B_BYTE_STB] |=> DMA_ADDR_O == {1'b0, $past(sb.stable[`B_DATA_HI:`B_DATA_LO])})
    else $error("byte dma address wrong");
  chk_word_addr: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R07
    (!sb.stable[`B_BYTE_STB] && sb.stable[`B_WORD_STB])
      |=> DMA_ADDR_O == {$past(sb.stable[`B_DATA_HI:`B_DATA_LO]), 1'b0})
    else $error("word dma address wrong");
  chk_addr0_release: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R10
    (dma8 || master) |=> !SYS_ADDR_BIT0_OE)
    else $error("address bit 0 still driven");
  chk_strobe_turn: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R16
    PERIPHERAL_BUS_GRANT |-> !AT_STROBES_N_OE)
    else $error("AT strobes driven in hold");
  chk_wait_extend: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R11
    (AT_CYCLE_BUSY && sb.stable[`B_ZERO_WAIT_N] && !sb.stable[`B_CH_READY])
      |=> AT_CYCLE_BUSY && !AT_CYCLE_DONE)
    else $error("cycle ended while not ready");
  chk_zero_wait: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R13
    (AT_CYCLE_BUSY && !sb.stable[`B_ZERO_WAIT_N]) |=> AT_CYCLE_DONE && !AT_CYCLE_BUSY)
    else $error("zero wait ignored");
  chk_reset_idle: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R21
    !$past(RST_B) |-> !CPU_HOLD_REQUEST && !PERIPHERAL_BUS_GRANT && !DMA_ADDR_OE)
    else $error("not idle after reset");
  chk_a20_mask: assert property (@(posedge REF_CLK) disable iff (!RST_B) // R17
    $past(RST_B) |-> ADDR20_MASK_N == $past(A20_GATE))
    else $error("address 20 mask wrong");
endmodule

// file: hold_arb_consts.svh
// holds the bit layout, reset values and counts of the hold arbiter
// assumes it is included by its bare name before any use of its macros
`ifndef HOLD_ARB_CONSTS_SVH
`define HOLD_ARB_CONSTS_SVH
// width of the synchronised pin vector
`define SYNC_W 23
// bit positions inside the synchronised pin vector
`define B_HOLD_REQ 0
`define B_CPU_GRANT 1
`define B_BYTE_STB 2
`define B_WORD_STB 3
`define B_BYTE_EN_N 4
`define B_WORD_EN_N 5
`define B_DATA_LO 6
`define B_DATA_HI 13
`define B_CH_READY 14
`define B_ZERO_WAIT_N 15
`define B_IO_WIDE_N 16
`define B_ADDR0 17
`define B_MEM_WIDE_N 18
`define B_AT_IO_READ_N_N 19
`define B_AT_IO_WRITE_N_N 20
`define B_MRD_N 21
`define B_MWR_N 22
// reset value: every active-low pin and channel ready idle high, the rest low
`define SYNC_RST 23'h7DC030
// wait states of a plain AT cycle; channel ready low holds the count at any point
`define AT_DEFAULT_WAITS 3'h4
// address bit 20 is masked from reset
`define A20_MASK_RST 1'b0
// captured DMA address after reset
`define DMA_ADDR_RST 9'h000
`endif

// file: hold_arb_pkg.sv
// holds the types shared by the hold arbiter and its pin synchroniser
// assumes hold_arb_consts.svh is on the include path
`include "hold_arb_consts.svh"
package hold_arb_pkg;
  // arbitration states, one-hot
  typedef enum logic [2:0] {
    ARB_IDLE  = 3'b001,
    ARB_REQ   = 3'b010,
    ARB_GRANT = 3'b100
  } arb_state_t;
  // vector of synchronised pin inputs
  typedef logic [`SYNC_W-1:0] sync_vec_t;
endpackage

// file: sync_bus_if.sv
// holds the carrier between the pin synchroniser and the arbiter
// assumes hold_arb_pkg is compiled first
`timescale 1ns/1ps
interface sync_bus_if;
  hold_arb_pkg::sync_vec_t raw;     // pin levels straight from the pads
  hold_arb_pkg::sync_vec_t stable;  // levels once two late stages agree
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// file: pin_sync.sv
// holds the three-stage synchroniser for the pin inputs the arbiter gathers in sb.raw
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "hold_arb_consts.svh"
module pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  sync_bus_if.sync bus
);
  hold_arb_pkg::sync_vec_t s1;  // first stage, read only by s2
  hold_arb_pkg::sync_vec_t s2;  // second stage
  hold_arb_pkg::sync_vec_t s3;  // third stage
  hold_arb_pkg::sync_vec_t st;  // accepted level
  localparam hold_arb_pkg::sync_vec_t RST = `SYNC_RST;

  // one chain per bit; a change counts once stages two and three agree,
  // which filters a single-cycle glitch at the cost of one extra cycle
  for (genvar i = 0; i < `SYNC_W; i++)
  begin : g_bit
    always_ff @(posedge clk)
    begin
      if (!rst_b)
      begin
        s1[i] <= RST[i];
        s2[i] <= RST[i];
        s3[i] <= RST[i];
        st[i] <= RST[i];
      end
      else
      begin
        s1[i] <= bus.raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i])
          st[i] <= s3[i];
      end
    end
  end

  assign bus.stable = st;
endmodule

// file: cpu_hold_model.sv
// cpu side of the hold handshake: floats its pins, then grants the bus
// assumes the arbiter clock and a synchronous active-low reset
`timescale 1ns/1ps
module cpu_hold_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       hold_req,  // hold request from the arbiter
  input  wire logic [7:0] delay,     // cycles spent floating pins first
  input  wire logic       drop,      // bench-ordered early release
  output logic            grant      // hold grant back to the arbiter
);
  logic [7:0] cnt;  // cycles since hold was seen
  // grant only once the pins have had time to float; a drop restarts it
  always_ff @(posedge clk)
  begin
    if (!rst_b || !hold_req || drop)
    begin
      cnt   <= 8'h00;
      grant <= 1'b0;
    end
    else if (cnt >= delay)
      grant <= 1'b1;
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// file: tb_hold_arbiter.sv
// self-checking bench for the hold arbiter with a cpu model beside it
// assumes the design files and cpu_hold_model are compiled first
`timescale 1ns/1ps
`include "hold_arb_consts.svh"
module tb_hold_arbiter;
  logic       clk, rst_b, hreq, bstb, wstb, ben_n, wen_n, cpu_a0, rdy, zw_n, start;
  logic       io_wide_slave_n_n, lhit, gate, tb_a0, tb_m16, cdrop;
  logic [7:0] xd, cdly;
  logic [3:0] cstb, tb_stb;
  wire        cgnt, hold, pgnt, daddr_oe, d8, d16, mst, a0_o, a0_oe, a0_s, done, busy;
  wire        io_act, m16_o, m16_oe, m_act, stb_oe, addr20_mask_n_n, ads_n, mio, wr, snp_oe;
  wire  [8:0] daddr;
  wire  [3:0] stb_o, dstb;
  // shared two-way pins resolve to whoever drives; idle level is the bench's
  wire        a0_i  = a0_oe ? a0_o : tb_a0;
  wire        m16_i = m16_oe ? m16_o : tb_m16;
  wire  [3:0] stb_i = stb_oe ? stb_o : tb_stb;
  int         error_cnt, tests_run, busy_len, cycle_cnt, i, m, ads_cnt;
  int         exp_q[$];  // expected busy lengths, negative means at least
  logic [31:0] rnd;

  hold_arbiter dut (.REF_CLK(clk), .RST_B(rst_b), .DMA_HOLD_REQUEST(hreq),
    .CPU_BUS_GRANT(cgnt), .CPU_HOLD_REQUEST(hold), .PERIPHERAL_BUS_GRANT(pgnt),
    .BYTE_DMA_ADDR_STROBE(bstb), .WORD_DMA_ADDR_STROBE(wstb),
    .BYTE_DMA_ADDR_ENABLE_N(ben_n), .WORD_DMA_ADDR_ENABLE_N(wen_n),
    .LOCAL_PERIPH_DATA_LOW(xd), .DMA_ADDR_O(daddr), .DMA_ADDR_OE(daddr_oe),
    .DMA8_CYCLE(d8), .DMA16_CYCLE(d16), .MASTER_CYCLE(mst), .CPU_ADDR_BIT0(cpu_a0),
    .SYS_ADDR_BIT0_I(a0_i), .SYS_ADDR_BIT0_O(a0_o), .SYS_ADDR_BIT0_OE(a0_oe),
    .SAMPLED_ADDR_BIT0(a0_s), .CHANNEL_READY(rdy), .ZERO_WAIT_N(zw_n),
    .AT_CYCLE_START(start), .AT_CYCLE_DONE(done), .AT_CYCLE_BUSY(busy),
    .IO_WIDE_SLAVE_N(io_wide_slave_n_n), .IO_WIDE_ACTIVE(io_act), .LOCAL_MEM_HIT(lhit),
    .MEM_WIDE_SLAVE_N_I(m16_i), .MEM_WIDE_SLAVE_N_O(m16_o),
    .MEM_WIDE_SLAVE_N_OE(m16_oe), .MEM_WIDE_ACTIVE(m_act), .CPU_AT_STROBES_N(cstb),
    .AT_STROBES_N_I(stb_i), .AT_STROBES_N_O(stb_o), .AT_STROBES_N_OE(stb_oe),
    .DMA_STROBES_N(dstb), .A20_GATE(gate), .ADDR20_MASK_N(addr20_mask_n_n),
    .CPU_ADDR_STATUS_N_O(ads_n), .CPU_MEM_OR_IO_N_O(mio), .CPU_WRITE_READ_N_O(wr),
    .SNOOP_OE(snp_oe));

  cpu_hold_model u_cpu (.clk(clk), .rst_b(rst_b), .hold_req(hold), .delay(cdly),
    .drop(cdrop), .grant(cgnt));

  // free-running clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // pseudo-random source, fixed start value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // counts a check and reports a mismatch at once
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // covers two synchroniser passes back to back, as a pin turnaround needs
  task automatic settle;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask

  // prints the counts and the verdict, then ends the run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one at cycle; the expected busy length goes on the queue first
  task automatic at_cycle(input int exp_len, input logic twice);
    @(posedge clk);
    exp_q.push_back(exp_len);
    start <= 1'b1;
    @(posedge clk);
    start <= twice;  // a start while busy must be ignored
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 60 && (busy === 1'b1 || done === 1'b1); i++) @(negedge clk);
  endtask

  // watcher: measures each at cycle and compares with the oldest note
  always @(negedge clk)
  begin
    if (rst_b && done === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected cycle end", 9'h001, 9'h000);
      else if (exp_q[0] < 0)
        check("stretched cycle", 9'(busy_len >= -exp_q.pop_front()), 9'h001);
      else
        check("cycle length", busy_len[8:0], 9'(exp_q.pop_front()));
      busy_len = 0;
    end
    else if (busy === 1'b1)
      busy_len++;
  end

  // counts snoop address-status pulses as the cpu would see them
  always @(negedge clk)
    if (ads_n === 1'b0)
      ads_cnt++;

  // hang guard: far above the under one thousand cycles the tests need
  always @(posedge clk)
  begin
    cycle_cnt++;
    if (cycle_cnt == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    {rst_b, hreq, bstb, wstb, start, lhit, gate, cdrop, cpu_a0} = '0;
    {ben_n, wen_n, rdy, zw_n, io_wide_slave_n_n, tb_a0, tb_m16} = '1;
    {xd, cdly, cstb, tb_stb, rnd} = {8'h00, 8'h00, 4'hF, 4'hF, 32'h4A1E};
    repeat (2) @(posedge clk);  // synchronous reset also clears the synchronisers
    rst_b <= 1'b1;
    @(negedge clk);
    check("hold after reset", hold, 1'b0);
    check("grant after reset", pgnt, 1'b0);
    check("dma addr oe after reset", daddr_oe, 1'b0);
    check("m16 oe idle", m16_oe, 1'b0);
    check("strobe oe idle", stb_oe, 1'b1);
    check("a0 oe idle", a0_oe, 1'b1);
    // at cycles: default, six spaced-out random default or zero-wait, then stretched
    at_cycle(`AT_DEFAULT_WAITS + 1, 1'b1);
    for (m = 0; m < 6; m++)
    begin
      rnd = lfsr(rnd);
      @(posedge clk);
      zw_n <= rnd[0];
      settle();
      at_cycle(rnd[0] ? `AT_DEFAULT_WAITS + 1 : 1, 1'b0);
    end
    @(posedge clk);
    zw_n <= 1'b1;
    rdy  <= 1'b0;
    settle();
    at_cycle(-20, 1'b0);
    repeat (20) @(negedge clk);
    check("busy while not ready", busy, 1'b1);
    @(posedge clk);
    rdy <= 1'b1;
    for (i = 0; i < 30 && busy === 1'b1; i++) @(negedge clk);
    // wide slave inputs, address bit 20 mask, own bit 0 and strobe outputs
    for (m = 0; m < 4; m++)
    begin
      rnd = lfsr(rnd);
      @(posedge clk);
      {io_wide_slave_n_n, tb_m16, gate, cpu_a0} <= rnd[3:0];
      cstb <= rnd[7:4];
      @(posedge clk);
      @(negedge clk);
      check("a20 mask", addr20_mask_n_n, rnd[1]);
      check("a0 out", a0_o, rnd[0]);
      check("strobes out", stb_o, rnd[7:4]);
      settle();
      check("io wide", io_act, !rnd[3]);
      check("mem wide", m_act, !rnd[2]);
    end
    @(posedge clk);
    {io_wide_slave_n_n, tb_m16, cstb} <= 6'h3F;
    // arbitration with a prompt and a slow cpu
    for (m = 0; m < 2; m++)
    begin
      @(posedge clk);
      cdly <= m ? 8'h1E : 8'h00;
      hreq <= 1'b1;
      for (i = 0; i < 12 && hold !== 1'b1; i++) @(negedge clk);
      check("hold request", hold, 1'b1);
      check("grant before cpu", pgnt, 1'b0);
      for (i = 0; i < 50 && pgnt !== 1'b1; i++) @(negedge clk);
      check("periph grant", pgnt, 1'b1);
      check("cpu had granted", cgnt, 1'b1);
      check("strobe oe in hold", stb_oe, 1'b0);
      // byte dma, word dma, master: decodes and pin turnaround
      for (int md = 0; md < 3; md++)
      begin
        rnd = lfsr(rnd);
        @(posedge clk);
        {ben_n, wen_n} <= (md == 0) ? 2'b01 : (md == 1) ? 2'b10 : 2'b11;
        tb_a0 <= rnd[8];
        xd    <= rnd[7:0];
        settle();
        check("dma8", d8, md == 0);
        check("dma16", d16, md == 1);
        check("master", mst, md == 2);
        check("a0 oe", a0_oe, md == 1);
        if (md != 1)
          check("a0 sampled", a0_s, rnd[8]);
        check("dma addr oe", daddr_oe, md != 2);
        @(posedge clk);
        bstb <= md != 1;  // master mode latches through the byte strobe too
        wstb <= md == 1;
        settle();
        @(posedge clk);
        {bstb, wstb} <= 2'b00;
        settle();
        check("dma addr", daddr, md == 1 ? {rnd[7:0], 1'b0} : {1'b0, rnd[7:0]});
        @(posedge clk);
        lhit <= 1'b1;  // a hit in a DMA cycle must not turn the pin around
        settle();
        check("m16 drive", {m16_oe, m16_o}, md == 2 ? 2'b10 : 2'b00);
        @(posedge clk);
        lhit <= 1'b0;
      end
      @(posedge clk);
      {ben_n, wen_n} <= 2'b11;
      // snooped memory read then write from the other master
      tb_stb  <= 4'hB;
      ads_cnt = 0;
      settle();
      check("snoop oe", snp_oe, 1'b1);
      check("snoop mem", mio, 1'b1);
      check("sampled strobes", dstb, 4'hB);
      @(posedge clk);
      tb_stb <= 4'h7;
      settle();
      check("snoop write", wr, 1'b1);
      check("snoop pulses", 9'(ads_cnt), 9'h001);
      @(posedge clk);
      tb_stb <= 4'hF;
      cdrop  <= 1'b1;
      settle();
      check("grant after cpu drop", pgnt, 1'b0);
      check("hold kept", hold, 1'b1);
      @(posedge clk);
      cdrop <= 1'b0;
      hreq  <= 1'b0;
      settle();
      check("hold released", {hold, pgnt}, 2'b00);
      check("strobe oe back", stb_oe, 1'b1);
    end
    stop_test();
  end
endmodule
